/* shared/qeo_consts.svh */
// Constants for the quadrature encoder output logic and its counter.
// Assumes a single 100 MHz system clock shared by both ends.
`ifndef QEO_CONSTS_SVH
`define QEO_CONSTS_SVH

// Clock and link timing.
`define QEO_CLK_MHZ          100
`define QEO_MAX_CHAN_KHZ     8000
`define QEO_EDGE_GAP_CYC     (((`QEO_CLK_MHZ * 1000) + (4 * `QEO_MAX_CHAN_KHZ) - 1) / (4 * `QEO_MAX_CHAN_KHZ))

// Scale geometry: one sine period of the scale in picometres.
`define QEO_SINE_PERIOD_PM   100000000

// Edges per sine period for each resolution choice.
`define QEO_EDGES_100NM      1000
`define QEO_EDGES_1UM        100
`define QEO_EDGES_10UM       10

// Sample width and analog front end thresholds, in raw sample units or products of them.
`define QEO_SAMPLE_W         12
`define QEO_TRACK_DEADBAND   30'sd4096
`define QEO_MIN_AMPL_SQ      27'd40000
`define QEO_REF_THRESH       13'sd512

// Sine shaping: bend of the parabola toward a sine, 0.225 in Q15.
`define QEO_SINE_BEND        32'd7373

`endif

/* shared/qeo_pkg.sv */
// Types shared by the encoder output end and the counter end.
// Assumes nothing beyond a SystemVerilog compiler.
package qeo_pkg;

   // Resolution chosen when the device is built.
   typedef enum logic [1:0] {
      QEO_RES_100NM = 2'b00,
      QEO_RES_1UM   = 2'b01,
      QEO_RES_10UM  = 2'b10
   } qeo_res_t;

   // Edge evaluation mode of the counter.
   typedef enum logic [1:0] {
      QEO_EVAL_SINGLE = 2'b00,
      QEO_EVAL_TWO    = 2'b01,
      QEO_EVAL_FOUR   = 2'b10
   } qeo_eval_t;

endpackage

/* shared/qeo_link_if.sv */
// Digital link between the encoder output end and the counter end.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface qeo_link_if;
   logic chan_a;
   logic chan_b;
   logic ref_mark;
   logic err_n;

   // Encoder output end drives the link.
   modport enc (
      output chan_a,
      output chan_b,
      output ref_mark,
      output err_n
   );

   // Counter end samples the link.
   modport cnt (
      input chan_a,
      input chan_b,
      input ref_mark,
      input err_n
   );
endinterface
`default_nettype wire

/* src/qeo_interp.sv */
// Encoder output end: tracks digitised sine/cosine samples and emits
// quadrature channels, a reference mark, an error level and two LEDs.
// Assumes samples arrive synchronous to clk_sys, one per cycle.
`timescale 1ns/100ps
`default_nettype none
`include "qeo_consts.svh"
module qeo_interp #(
   parameter qeo_pkg::qeo_res_t RES = qeo_pkg::QEO_RES_100NM,
   parameter int                SW  = `QEO_SAMPLE_W
) (
   // Clock and reset.
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   // Digitised differential scale signals.
   input  wire logic signed [SW-1:0] raw_sine_pos,
   input  wire logic signed [SW-1:0] raw_sine_neg,
   input  wire logic signed [SW-1:0] raw_cosine_pos,
   input  wire logic signed [SW-1:0] raw_cosine_neg,
   input  wire logic signed [SW-1:0] raw_index_pos,
   input  wire logic signed [SW-1:0] raw_index_neg,
   // Board status.
   input  wire logic                 power_good,
   input  wire logic                 sensor_present,
   // Indicators.
   output logic                      led_green,
   output logic                      led_red,
   // Link to the counter.
   qeo_link_if.enc                   link
);
   import qeo_pkg::*;

   // Edges per sine period for the built resolution.
   function automatic int edges_for(input qeo_res_t r);
      unique case (r)
         QEO_RES_100NM: edges_for = `QEO_EDGES_100NM;
         QEO_RES_1UM:   edges_for = `QEO_EDGES_1UM;
         QEO_RES_10UM:  edges_for = `QEO_EDGES_10UM;
         default:       edges_for = `QEO_EDGES_100NM;
      endcase
   endfunction

   // Sine of a 16-bit angle, scaled to signed 16 bits. A bare parabola is off by
   // several percent, enough to pull the lock point past a half step, so it is
   // bent toward a sine, which leaves an error near a thousandth.
   function automatic logic signed [15:0] par_sin(input logic [15:0] ang);
      logic [29:0] prod;
      logic [16:0] mag;
      logic [31:0] sq;
      logic [31:0] bend;
      prod = 30'(ang[14:0]) * 30'(16'h8000 - {1'b0, ang[14:0]});
      mag  = prod[29:13];
      if (mag > 17'h07fff) begin
         mag = 17'h07fff;
      end
      sq   = 32'(mag[15:0]) * 32'(mag[15:0]);
      bend = 32'(mag[15:0]) - (sq >> 15);                    // Is m(1-m), never negative.
      bend = (bend * `QEO_SINE_BEND) >> 15;
      mag  = mag - 17'(bend);
      par_sin = ang[15] ? -$signed(mag[15:0]) : $signed(mag[15:0]);
   endfunction

   // Phase error of the input against angle a: amplitude times sin(input - a).
   function automatic logic signed [29:0] phase_err(input logic signed [SW:0] s,
                                                    input logic signed [SW:0] c,
                                                    input logic [15:0]       a);
      logic signed [15:0] es;
      logic signed [15:0] ec;
      es        = par_sin(a);
      ec        = par_sin(16'(a + 16'h4000));
      phase_err = 30'(s * ec) - 30'(c * es);
   endfunction

   localparam int          EDGES    = edges_for(RES);
   localparam int          IW       = $clog2(EDGES);
   localparam logic [IW-1:0] IDX_TOP = IW'(EDGES - 1);
   localparam logic [31:0] ANG_MUL  = 32'(64'h1_0000_0000 / EDGES);
   // Half of one edge step, as a 16-bit angle.
   localparam logic [15:0] HALF_STEP = 16'(ANG_MUL >> 17);
   localparam int          GAP      = `QEO_EDGE_GAP_CYC;
   localparam logic [3:0]  GAP_LOAD = 4'(GAP - 1);

   // Differential samples, one bit wider than the raw inputs.
   logic signed [SW:0] sin_d;
   logic signed [SW:0] cos_d;
   logic signed [SW:0] idx_d;
   assign sin_d = {raw_sine_pos[SW-1], raw_sine_pos} - {raw_sine_neg[SW-1], raw_sine_neg};
   assign cos_d = {raw_cosine_pos[SW-1], raw_cosine_pos}
                - {raw_cosine_neg[SW-1], raw_cosine_neg};
   assign idx_d = {raw_index_pos[SW-1], raw_index_pos} - {raw_index_neg[SW-1], raw_index_neg};

   // Tracking state: edge index within the sine period and pacing gap.
   logic [IW-1:0] idx;
   logic [IW-1:0] next_idx;
   logic [3:0]    gap;
   logic [3:0]    next_gap;
   logic          ref_armed;
   logic          next_ref_armed;
   logic          chan_a;
   logic          next_chan_a;
   logic          chan_b;
   logic          next_chan_b;
   logic          ref_mark;
   logic          next_ref_mark;
   logic          err_n;
   logic          next_err_n;
   logic          next_led_green;
   logic          next_led_red;

   // Angle of the tracked position and its phase error against the input.
   logic [47:0]          ang_prod;
   logic [15:0]          ang;
   logic [15:0]          ang_hi;
   logic [15:0]          ang_lo;
   logic signed [29:0]   err_hi;
   logic signed [29:0]   err_lo;
   logic [26:0]          ampl_sq;
   logic                 fault;

   // Phase detector, taken against the two half-step boundaries around the index
   // rather than the index itself. The input must pass a boundary before the index
   // follows, so a position that rests near an edge cannot hunt to and fro.
   always_comb begin
      ang_prod = 48'(idx) * 48'(ANG_MUL);
      ang      = ang_prod[31:16];
      ang_hi   = 16'(ang + HALF_STEP);
      ang_lo   = 16'(ang - HALF_STEP);
      err_hi   = phase_err(sin_d, cos_d, ang_hi);
      err_lo   = phase_err(sin_d, cos_d, ang_lo);
      ampl_sq  = 27'(sin_d * sin_d) + 27'(cos_d * cos_d);
      fault    = !sensor_present || (ampl_sq < `QEO_MIN_AMPL_SQ);
   end

   // Next tracking index, one edge at most per paced slot.
   always_comb begin
      next_idx = idx;
      next_gap = (gap != 4'h0) ? 4'(gap - 4'h1) : 4'h0;
      if (gap == 4'h0 && !fault) begin
         // Past the upper boundary the index steps up, short of the lower one
         // it steps down; between the two it holds.
         if (err_hi > `QEO_TRACK_DEADBAND) begin
            next_idx = (idx == IDX_TOP) ? '0 : IW'(idx + 1'b1);
            next_gap = GAP_LOAD;
         end else if (err_lo < -`QEO_TRACK_DEADBAND) begin
            next_idx = (idx == '0) ? IDX_TOP : IW'(idx - 1'b1);
            next_gap = GAP_LOAD;
         end
      end
   end

   // Channel levels: a Gray code of the low index bits, A leading B.
   always_comb begin
      next_chan_a = next_idx[1] ^ next_idx[0];
      next_chan_b = next_idx[1];
      // Each index step moves exactly one channel edge.
   end

   // Reference mark: armed by the index track, shown at index zero.
   always_comb begin
      next_ref_armed = ref_armed;
      if (ref_mark && next_idx != '0) begin
         next_ref_armed = 1'b0;
      end
      if (idx_d > `QEO_REF_THRESH) begin
         next_ref_armed = 1'b1;
      end
      next_ref_mark = next_ref_armed && (next_idx == '0);
   end

   // Status outputs and indicators.
   always_comb begin
      next_err_n     = !fault;
      next_led_green = power_good;
      next_led_red   = power_good && fault;
   end

   // Register all state and outputs.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idx       <= '0;
         gap       <= 4'h0;
         ref_armed <= 1'b0;
         chan_a    <= 1'b0;
         chan_b    <= 1'b0;
         ref_mark  <= 1'b0;
         err_n     <= 1'b0;
         led_green <= 1'b0;
         led_red   <= 1'b0;
      end else begin
         idx       <= next_idx;
         gap       <= next_gap;
         ref_armed <= next_ref_armed;
         chan_a    <= next_chan_a;
         chan_b    <= next_chan_b;
         ref_mark  <= next_ref_mark;
         err_n     <= next_err_n;
         led_green <= next_led_green;
         led_red   <= next_led_red;
      end
   end

   // Drive the link straight from the output flip-flops.
   assign link.chan_a   = chan_a;
   assign link.chan_b   = chan_b;
   assign link.ref_mark = ref_mark;
   assign link.err_n    = err_n;

endmodule
`default_nettype wire

/* src/qeo_counter.sv */
// Counter end: counts quadrature edges in a selected evaluation mode,
// captures the count at the reference mark and flags illegal steps.
// Assumes the link is driven on the same clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "qeo_consts.svh"
module qeo_counter #(
   parameter int CW    = 32,
   parameter int EDGES = `QEO_EDGES_100NM
) (
   // Clock and reset.
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Link from the encoder end.
   qeo_link_if.cnt                link,
   // User side control.
   input  wire qeo_pkg::qeo_eval_t eval_mode,
   input  wire logic              illegal_clr,
   // User side results.
   output logic signed [CW-1:0]   count,
   output logic signed [CW-1:0]   ref_count,
   output logic                   ref_seen,
   output logic                   illegal,
   output logic                   enc_error,
   output logic [31:0]            step_pm
);
   import qeo_pkg::*;

   localparam logic [31:0] OUT_PERIOD_PM = 32'((64'd4 * `QEO_SINE_PERIOD_PM) / EDGES);

   // Previous samples for transition detection.
   logic                 a_q;
   logic                 b_q;
   logic                 r_q;
   logic signed [CW-1:0] next_count;
   logic signed [CW-1:0] next_ref_count;
   logic                 next_ref_seen;
   logic                 next_illegal;
   logic                 next_enc_error;
   logic [31:0]          next_step_pm;
   logic                 a_rise;
   logic                 a_fall;
   logic                 a_chg;
   logic                 b_chg;
   logic                 up;
   logic                 dn;

   // Edge decode and direction; sampled at 100 MHz, ample for 8 MHz.
   always_comb begin
      a_chg  = link.chan_a ^ a_q;
      b_chg  = link.chan_b ^ b_q;
      a_rise = a_chg && link.chan_a;
      a_fall = a_chg && !link.chan_a;
      up     = 1'b0;
      dn     = 1'b0;
      if (a_chg && b_chg) begin
         up = 1'b0;
      end else begin
         unique case (eval_mode)
            QEO_EVAL_SINGLE: begin
               up = a_rise && !link.chan_b;
               dn = a_fall && !link.chan_b;
            end
            QEO_EVAL_TWO: begin
               up = (a_rise && !link.chan_b) || (a_fall && link.chan_b);
               dn = (a_rise && link.chan_b) || (a_fall && !link.chan_b);
            end
            default: begin
               // Four-edge, also taken for the unused code.
               up = (a_chg && (link.chan_a != link.chan_b))
                  || (b_chg && (link.chan_a == link.chan_b));
               dn = (a_chg && (link.chan_a == link.chan_b))
                  || (b_chg && (link.chan_a != link.chan_b));
            end
         endcase
      end
   end

   // Next count, reference capture, flags and step size.
   always_comb begin
      next_count = count;
      if (up) begin
         next_count = CW'(count + 1'b1);
      end else if (dn) begin
         next_count = CW'(count - 1'b1);
      end
      next_ref_count = ref_count;
      next_ref_seen  = 1'b0;
      if (link.ref_mark && !r_q) begin
         next_ref_count = next_count;
         next_ref_seen  = 1'b1;
      end
      next_illegal = illegal;
      if (illegal_clr) begin
         next_illegal = 1'b0;
      end
      if (a_chg && b_chg) begin
         next_illegal = 1'b1;
      end
      next_enc_error = !link.err_n;
      unique case (eval_mode)
         QEO_EVAL_SINGLE: next_step_pm = OUT_PERIOD_PM;
         QEO_EVAL_TWO:    next_step_pm = OUT_PERIOD_PM >> 1;
         default:         next_step_pm = OUT_PERIOD_PM >> 2;
      endcase
   end

   // Register all state and outputs.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         a_q       <= 1'b0;
         b_q       <= 1'b0;
         r_q       <= 1'b0;
         count     <= '0;
         ref_count <= '0;
         ref_seen  <= 1'b0;
         illegal   <= 1'b0;
         enc_error <= 1'b0;
         step_pm   <= 32'h0;
      end else begin
         a_q       <= link.chan_a;
         b_q       <= link.chan_b;
         r_q       <= link.ref_mark;
         count     <= next_count;
         ref_count <= next_ref_count;
         ref_seen  <= next_ref_seen;
         illegal   <= next_illegal;
         enc_error <= next_enc_error;
         step_pm   <= next_step_pm;
      end
   end

endmodule
`default_nettype wire

/* test/qeo_link_chk.sv */
// Checker for the link between the encoder output end and the counter end.
// Assumes it sits beside the link interface and sees its signals directly.
`timescale 1ns/100ps
`default_nettype none
module qeo_link_chk (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link signals.
   input wire logic chan_a,
   input wire logic chan_b,
   input wire logic ref_mark,
   input wire logic err_n
);
   logic       prev_a;
   logic       prev_b;
   logic       moved;
   logic [2:0] quiet;
   logic [2:0] next_quiet;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Counts quiet cycles since the last channel change, saturating at seven.
   always_comb begin
      moved = (chan_a != prev_a) || (chan_b != prev_b);
      next_quiet = quiet;
      if (moved) begin
         next_quiet = 3'h0;
      end else if (quiet != 3'h7) begin
         next_quiet = quiet + 3'h1;
      end
   end

   // Registers the previous channel levels and the quiet count.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_a <= 1'b0;
         prev_b <= 1'b0;
         quiet  <= 3'h7;
      end else begin
         prev_a <= chan_a;
         prev_b <= chan_b;
         quiet  <= next_quiet;
      end
   end

   a_gray_step: assert property (!($changed(chan_a) && $changed(chan_b)))
      else $error("Both channels changed in one cycle.");
   a_edge_gap: assert property (($changed(chan_a) || $changed(chan_b)) |=>
      ($stable(chan_a) && $stable(chan_b)) [*3]) else $error("Steps too close.");
   a_gap_count: assert property (moved |-> quiet >= 3'h3)
      else $error("Step came before three quiet cycles.");
   a_ref_home: assert property (ref_mark |-> (!chan_a && !chan_b))
      else $error("Reference mark away from the home state.");
   a_ref_leave: assert property ($fell(ref_mark) |-> ($changed(chan_a) || $changed(chan_b)))
      else $error("Reference mark dropped without a step.");
   a_ref_holds: assert property ($rose(ref_mark) |=> (ref_mark || !$stable(chan_a) ||
      !$stable(chan_b))) else $error("Reference mark too short.");
   a_step_healthy: assert property (($changed(chan_a) || $changed(chan_b)) |-> err_n)
      else $error("Step taken while an error is shown.");
   a_fault_freeze: assert property ((!err_n ##1 !err_n) |-> ($stable(chan_a) && $stable(chan_b)))
      else $error("Channels moved during an error.");
endmodule
`default_nettype wire

/* test/tb_quadrature_encoder_output_eval.sv */
// Testbench: encoder output end driving the counter end, plus a second counter
// fed by the bench with faulty steps. Assumes the shared package and link.
`timescale 1ns/100ps
`default_nettype none
`include "qeo_consts.svh"
module tb_quadrature_encoder_output_eval;
   import qeo_pkg::*;
   localparam int EDGES = `QEO_EDGES_1UM;
   localparam int SW    = `QEO_SAMPLE_W;
   logic                clk_sys = 1'b0;
   logic                rst_n = 1'b0;
   logic signed [SW-1:0] sin_p, sin_n, cos_p, cos_n, idx_p, idx_n;
   logic                power_good, sensor_present, led_green, led_red;
   logic                illegal_clr, ref_seen, illegal, enc_error, illegal2, enc_error2;
   qeo_eval_t           eval_mode;
   logic signed [31:0]  count, ref_count, count2;
   logic [31:0]         step_pm;
   int                  errors = 0, checked = 0, exp_cnt = 0, pos = 0, ref_hits = 0;

   qeo_link_if link();
   qeo_link_if link2();
   qeo_interp #(.RES(QEO_RES_1UM)) qeo_interp_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .raw_sine_pos(sin_p), .raw_sine_neg(sin_n), .raw_cosine_pos(cos_p),
      .raw_cosine_neg(cos_n), .raw_index_pos(idx_p), .raw_index_neg(idx_n),
      .power_good(power_good), .sensor_present(sensor_present), .led_green(led_green),
      .led_red(led_red), .link(link));
   qeo_counter #(.EDGES(EDGES)) qeo_counter_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(link), .eval_mode(eval_mode), .illegal_clr(illegal_clr), .count(count),
      .ref_count(ref_count), .ref_seen(ref_seen), .illegal(illegal), .enc_error(enc_error),
      .step_pm(step_pm));
   qeo_counter #(.EDGES(EDGES)) qeo_counter_fault_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(link2), .eval_mode(QEO_EVAL_FOUR), .illegal_clr(illegal_clr), .count(count2),
      .ref_count(), .ref_seen(), .illegal(illegal2), .enc_error(enc_error2), .step_pm());
   qeo_link_chk qeo_link_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .chan_a(link.chan_a),
      .chan_b(link.chan_b), .ref_mark(link.ref_mark), .err_n(link.err_n));

   // Free-running system clock and a tally of reference pulses.
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (ref_seen === 1'b1) begin
         ref_hits++;
      end
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Drives sine and cosine for a scale phase given in output steps.
   task automatic set_phase(input int p);
      int s;
      int c;
      s = $rtoi(1600.0 * $sin(6.2831853 * p / EDGES));
      c = $rtoi(1600.0 * $cos(6.2831853 * p / EDGES));
      sin_p = SW'(s / 2);
      sin_n = SW'(s / 2 - s);
      cos_p = SW'(c / 2);
      cos_n = SW'(c / 2 - c);
   endtask

   // Moves n steps one at a time and predicts the count for the current mode.
   task automatic move(input int n);
      int dir;
      int m;
      dir = (n > 0) ? 1 : -1;
      repeat ((n > 0) ? n : -n) begin
         m = pos & 3;
         case (eval_mode)
            QEO_EVAL_SINGLE: if ((dir > 0 && m == 0) || (dir < 0 && m == 1)) exp_cnt += dir;
            QEO_EVAL_TWO: if ((dir > 0) == (m == 0 || m == 2)) exp_cnt += dir;
            default: exp_cnt += dir;
         endcase
         pos += dir;
         set_phase(pos);
         tick(8);
      end
      tick(16);
   endtask

   // Healthy board: green only, error output high, no illegal step counted.
   task automatic t_health;
      check("led_green", led_green, 1'b1);
      check("led_red", led_red, 1'b0);
      check("err_n", link.err_n, 1'b1);
      check("enc_error", enc_error, 1'b0);
      check("illegal", illegal, 1'b0);
   endtask

   // Each evaluation mode: step size and odd moves both ways; then a full period in four-edge mode.
   task automatic t_modes;
      qeo_eval_t modes [3] = '{QEO_EVAL_SINGLE, QEO_EVAL_TWO, QEO_EVAL_FOUR};
      for (int i = 0; i < 3; i++) begin
         eval_mode = modes[i];
         tick(2);
         check("step_pm", step_pm, (4 * `QEO_SINE_PERIOD_PM / EDGES) >> i);
         move(9);
         check("count up", count, exp_cnt);
         move(-9);
         check("count down", count, exp_cnt);
      end
      move(EDGES);
      check("count period", count, EDGES);
      move(-EDGES);
      check("count back", count, 0);
      // A twelve-step jump is followed at the fastest paced step rate.
      pos += 12;
      exp_cnt += 12;
      set_phase(pos);
      tick(80);
      check("count fast up", count, exp_cnt);
      pos -= 12;
      exp_cnt -= 12;
      set_phase(pos);
      tick(80);
      check("count fast down", count, exp_cnt);
   endtask

   // Arms the reference, returns home, then leaves home again.
   task automatic t_ref;
      move(6);
      idx_p = SW'(600);
      idx_n = -SW'(100);
      tick(4);
      idx_p = '0;
      idx_n = '0;
      move(-6);
      check("ref_mark", link.ref_mark, 1'b1);
      check("ref_seen", ref_hits, 1);
      check("ref_count", ref_count, exp_cnt);
      move(2);
      check("ref_mark off", link.ref_mark, 1'b0);
      move(-2);
   endtask

   // Sensor missing, then power lost.
   task automatic t_fault;
      sensor_present = 1'b0;
      tick(3);
      check("led_red", led_red, 1'b1);
      check("led_green", led_green, 1'b1);
      check("err_n", link.err_n, 1'b0);
      check("enc_error", enc_error, 1'b1);
      set_phase(pos + 6);
      tick(40);
      check("count frozen", count, exp_cnt);
      set_phase(pos);
      tick(20);
      sensor_present = 1'b1;
      tick(3);
      t_health();
      power_good = 1'b0;
      tick(3);
      check("led_green off", led_green, 1'b0);
      check("led_red off", led_red, 1'b0);
      power_good = 1'b1;
      tick(3);
   endtask

   // Second counter: a legal step, then both channels changing at once.
   task automatic t_illegal;
      link2.chan_b = 1'b1;
      tick(10);
      check("count2 step", count2, -1);
      link2.chan_a = 1'b1;
      link2.chan_b = 1'b0;
      tick(3);
      check("illegal2", illegal2, 1'b1);
      check("count2 held", count2, -1);
      illegal_clr = 1'b1;
      tick(1);
      illegal_clr = 1'b0;
      tick(2);
      check("illegal2 clear", illegal2, 1'b0);
      link2.err_n = 1'b0;
      tick(3);
      check("enc_error2", enc_error2, 1'b1);
   endtask

   task automatic test_done;
      $display("Checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence after a sixteen-cycle reset.
   initial begin
      set_phase(0);
      idx_p = '0;
      idx_n = '0;
      power_good = 1'b1;
      sensor_present = 1'b1;
      illegal_clr = 1'b0;
      eval_mode = QEO_EVAL_FOUR;
      link2.chan_a = 1'b0;
      link2.chan_b = 1'b0;
      link2.ref_mark = 1'b0;
      link2.err_n = 1'b1;
      tick(16);
      rst_n = 1'b1;
      tick(4);
      t_health();
      t_modes();
      t_ref();
      t_fault();
      t_illegal();
      test_done();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #200000;
      errors++;
      test_done();
   end
endmodule
`default_nettype wire
